// ===== include/bfg_pkg.sv
// Package for the boot section flash access guard
package bfg_pkg;
    localparam int ADDR_W          = 13;
    localparam int SYNC_STAGES     = 3;
    localparam logic [1:0] LOCK_RESET = 2'h3;
    localparam logic [1:0] BOOT_SIZE_RESET = 2'h0;
    // Boot region start per boot-size setting, word addresses
    localparam logic [12:0] BOOT_START_0 = 13'h1c00;
    localparam logic [12:0] BOOT_START_1 = 13'h1e00;
    localparam logic [12:0] BOOT_START_2 = 13'h1f00;
    localparam logic [12:0] BOOT_START_3 = 13'h1f80;
    // First word of the stalling region
    localparam logic [12:0] STALL_START  = 13'h1c00;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_STORE,
        OP_LOAD,
        OP_PROG
    } bfg_op_t;

    typedef struct packed {
        bfg_op_t            op;
        logic [ADDR_W-1:0]  exec_addr;
        logic [ADDR_W-1:0]  target_addr;
    } bfg_req_t;

    typedef struct packed {
        logic app_lock_high;
        logic app_lock_low;
        logic boot_lock_high;
        logic boot_lock_low;
    } bfg_locks_t;
endpackage : bfg_pkg

// ===== sim/bfg_cpu_model.sv
// CPU core and flash timer model facing the access guard
`timescale 1ns/1ps
module bfg_cpu_model #(
    parameter int PROG_CYCLES = 20
) (
    input  wire logic         clk,
    input  wire logic         prog_start,
    output bfg_pkg::bfg_req_t req,
    output logic              ce,
    output logic              prog_done,
    output logic              region_read_reenable
);
    initial begin
        req                  = '0;
        ce                   = 1'h1;
        prog_done            = 1'h0;
        region_read_reenable = 1'h0;
    end
    // Completion pulse a fixed time after each start
    always @(posedge prog_start) begin
        repeat (PROG_CYCLES) @(posedge clk);
        #1 prog_done = 1'h1;
        @(posedge clk);
        #1 prog_done = 1'h0;
    end
    // One request held across exactly one sampling edge
    task automatic issue(input bfg_pkg::bfg_op_t op, input logic [12:0] ex,
                         input logic [12:0] tg);
        req = '{op, ex, tg};
        @(posedge clk);
        #1;
        req = '0;
    endtask : issue
    // Request presented while the clock enable is low
    task automatic issue_frozen(input bfg_pkg::bfg_op_t op, input logic [12:0] ex,
                                input logic [12:0] tg);
        ce  = 1'h0;
        req = '{op, ex, tg};
        @(posedge clk);
        #1;
        req = '0;
        ce  = 1'h1;
    endtask : issue_frozen
    // Reopens the concurrent region after programming
    task automatic clear_busy();
        region_read_reenable = 1'h1;
        @(posedge clk);
        #1;
        region_read_reenable = 1'h0;
    endtask : clear_busy
endmodule : bfg_cpu_model

// ===== sim/testbench.sv
// Self-checking testbench for the access guard
`timescale 1ns/1ps
module testbench;
    logic                clk = 1'h0;
    logic                resetn, ce, prog_done, rre, lock_write_en, chip_erase;
    logic                vectors_in_boot, sg, lg, rej, pst, stall, busy, irq;
    logic [1:0]          boot_size_fuses, general_lock_mode;
    logic [3:0]          lk;
    logic [3:0]          e4;
    logic [12:0]         ex, tg;
    logic [12:0]         bs [4] = '{bfg_pkg::BOOT_START_0, bfg_pkg::BOOT_START_1,
                                    bfg_pkg::BOOT_START_2, bfg_pkg::BOOT_START_3};
    bfg_pkg::bfg_req_t   req;
    bfg_pkg::bfg_locks_t lock_write, locks;
    bfg_pkg::bfg_op_t    op;
    int                  bad_count = 0, num_checks = 0, cycles = 0;

    always #2 clk = ~clk;
    bfg_guard u_bfg_guard (.clk(clk), .resetn(resetn), .ce(ce), .req(req),
        .prog_done(prog_done), .region_read_reenable(rre), .boot_size_fuses(boot_size_fuses),
        .lock_write(lock_write), .lock_write_en(lock_write_en), .chip_erase(chip_erase),
        .vectors_in_boot(vectors_in_boot), .general_lock_mode(general_lock_mode),
        .store_grant(sg), .load_grant(lg), .access_reject(rej), .prog_start(pst),
        .cpu_stall(stall), .region_busy_flag(busy), .irq_mask(irq), .locks(locks));
    bfg_cpu_model u_bfg_cpu_model (.clk(clk), .prog_start(pst), .req(req), .ce(ce),
        .prog_done(prog_done), .region_read_reenable(rre));

    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc
    task automatic lock_op(input logic er, input logic [3:0] v);
        chip_erase    = er;
        lock_write    = v;
        lock_write_en = ~er;
        wait_cyc(1);
        chip_erase    = 1'h0;
        lock_write_en = 1'h0;
    endtask : lock_op
    task automatic do_reset(input logic [1:0] fuse);
        resetn          = 1'h0;
        boot_size_fuses = fuse;
        wait_cyc(3);
        check("reset", {sg, lg, rej, pst, stall, busy, irq, locks}, 11'h00f);
        resetn = 1'h1;
        wait_cyc(1);
    endtask : do_reset
    function automatic logic [3:0] expect_of(input bfg_pkg::bfg_op_t o, input logic [12:0] b);
        logic eb, tb, r, q;
        eb = ex >= b;
        tb = tg >= b;
        q  = eb ? (!vectors_in_boot && !lk[1]) : (vectors_in_boot && !lk[3]);
        if (o == bfg_pkg::OP_LOAD)
            r = eb ? (!tb && !lk[3]) : (tb && !lk[1]);
        else
            r = !eb || (tb ? !lk[0] : !lk[2]);
        return {!r && o != bfg_pkg::OP_LOAD, !r && o == bfg_pkg::OP_LOAD, r, q};
    endfunction : expect_of

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(45));
        {chip_erase, lock_write_en, vectors_in_boot, general_lock_mode} = '0;
        lock_write = 4'hf;
        do_reset(2'h0);
        u_bfg_cpu_model.issue(bfg_pkg::OP_PROG, 13'h1f90, 13'h0100);
        check("walk", {sg, pst, busy, stall}, 4'he);
        u_bfg_cpu_model.issue(bfg_pkg::OP_LOAD, 13'h1f90, 13'h0100);
        check("blocked", {lg, rej}, 2'h0);
        u_bfg_cpu_model.issue(bfg_pkg::OP_LOAD, 13'h1f90, 13'h1d00);
        check("stall_load", {lg, rej}, 2'h2);
        u_bfg_cpu_model.clear_busy();
        check("busy_held", busy, 1'h1);
        wait_cyc(25);
        u_bfg_cpu_model.clear_busy();
        check("busy_clr", busy, 1'h0);
        $display("Test walk done");
        u_bfg_cpu_model.issue(bfg_pkg::OP_PROG, 13'h1c10, 13'h1c40);
        check("stall_on", {pst, stall}, 2'h3);
        wait_cyc(15);
        check("stall_mid", stall, 1'h1);
        wait_cyc(10);
        check("stall_end", stall, 1'h0);
        u_bfg_cpu_model.issue(bfg_pkg::OP_PROG, 13'h0200, 13'h0300);
        check("app_prog", {sg, rej, pst}, 3'h2);
        lock_op(1'h0, 4'h0);
        lock_op(1'h0, 4'hf);
        check("lock_and", locks, 4'h0);
        lock_op(1'h1, 4'h0);
        check("erase", locks, 4'hf);
        u_bfg_cpu_model.issue_frozen(bfg_pkg::OP_PROG, 13'h1f90, 13'h0100);
        check("frozen", {sg, lg, rej, pst, busy}, 5'h00);
        $display("Test stall and locks done");
        for (int f = 0; f < 4; f++) begin
            do_reset(f[1:0]);
            for (int i = 0; i < 60; i++) begin
                lk = 4'($urandom);
                lock_op(1'h1, 4'h0);
                lock_op(1'h0, lk);
                vectors_in_boot   = 1'($urandom);
                general_lock_mode = 2'($urandom);
                op = ($urandom_range(1) == 1) ? bfg_pkg::OP_LOAD : bfg_pkg::OP_STORE;
                ex = (i % 4 == 0) ? bs[f] : 13'($urandom);
                tg = (i % 4 == 1) ? bs[f] - 13'h1 : 13'($urandom);
                e4 = expect_of(op, bs[f]);
                u_bfg_cpu_model.issue(op, ex, tg);
                check("rand", {sg, lg, rej, irq}, e4);
                check("rand_pst", pst, 1'h0);
            end
            $display("Test random fuse %0d done", f);
        end
        print_verdict();
    end
endmodule : testbench

// ===== verilog/bfg_guard.sv
// Access guard for program-memory self-programming
//
// Contract
// - Stores executed from application region are rejected
// - Boot-region stores may program any page
// - Boot boundary follows boot-size fuses
// - Concurrent-region programming keeps CPU running
// - Stalling-region programming stalls the CPU
// - Boot region always inside stalling region
// - Busy flag set while region blocked
// - Two independent two-bit lock settings held
// - Locks only cleared by chip erase or reset
// - General lock modes do not gate accesses
// - Application locks 11: no restriction
// - Application locks 10: stores rejected
// - Application locks 00: stores, cross loads rejected
// - Application locks 01: cross loads rejected
// - Boot locks 11: no restriction
// - Boot locks 10: stores rejected
// - Boot locks 00: stores, cross loads rejected
// - Boot locks 01: cross loads rejected
`timescale 1ns/1ps
module bfg_guard #(
    parameter int ADDR_W = bfg_pkg::ADDR_W
) (
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic                ce,
    input  wire bfg_pkg::bfg_req_t   req,
    input  wire logic                prog_done,
    input  wire logic                region_read_reenable,
    input  wire logic [1:0]          boot_size_fuses,
    input  wire bfg_pkg::bfg_locks_t lock_write,
    input  wire logic                lock_write_en,
    input  wire logic                chip_erase,
    input  wire logic                vectors_in_boot,
    input  wire logic [1:0]          general_lock_mode,
    output logic                     store_grant,
    output logic                     load_grant,
    output logic                     access_reject,
    output logic                     prog_start,
    output logic                     cpu_stall,
    output logic                     region_busy_flag,
    output logic                     irq_mask,
    output bfg_pkg::bfg_locks_t      locks
);
    // Address decoding is built for the package width only
    if (ADDR_W != bfg_pkg::ADDR_W) begin : g_addr_check
        $error("bfg_guard: ADDR_W must match package");
    end

    function automatic logic in_boot(input logic [ADDR_W-1:0] a, input logic [1:0] sz);
        logic [ADDR_W-1:0] start;
        start = bfg_pkg::BOOT_START_0;
        case (sz)
            2'h0:    start = bfg_pkg::BOOT_START_0;
            2'h1:    start = bfg_pkg::BOOT_START_1;
            2'h2:    start = bfg_pkg::BOOT_START_2;
            default: start = bfg_pkg::BOOT_START_3;
        endcase
        return a >= start;
    endfunction : in_boot

    // Boot-size fuses are caught once after reset release
    logic [1:0] boot_size;
    logic       size_caught;
    logic       prog_active;
    logic       prog_stalls;
    logic       lock_busy;

    // Boot start never below stall start, so boot stays inside stalling region
    wire exec_boot   = in_boot(req.exec_addr, boot_size);
    wire target_boot = in_boot(req.target_addr, boot_size);
    wire target_stall = req.target_addr >= bfg_pkg::STALL_START;
    wire exec_stall  = req.exec_addr >= bfg_pkg::STALL_START;

    // Locks are 1 unprogrammed; general_lock_mode deliberately unused here
    wire app_store_lock  = ~locks.app_lock_low;
    wire app_read_lock   = ~locks.app_lock_high;
    wire boot_store_lock = ~locks.boot_lock_low;
    wire boot_read_lock  = ~locks.boot_lock_high;

    wire is_store = (req.op == bfg_pkg::OP_STORE) || (req.op == bfg_pkg::OP_PROG);
    wire is_load  = req.op == bfg_pkg::OP_LOAD;

    // Stores only from boot region, to any page not store-locked
    wire store_ok = exec_boot &&
                    !(target_boot ? boot_store_lock : app_store_lock);
    // Cross-region loads are refused by the read lock of the target region
    wire load_ok  = target_boot ? !(boot_read_lock && !exec_boot)
                                : !(app_read_lock && exec_boot);
    // Loads from the concurrent region are blocked while it is busy
    wire busy_block = region_busy_flag && !target_stall;
    wire next_store_grant = is_store && store_ok && !lock_busy;
    wire next_load_grant  = is_load && load_ok && !busy_block;
    wire next_reject = (is_store && !store_ok) || (is_load && !load_ok);
    wire next_prog_start = next_store_grant && (req.op == bfg_pkg::OP_PROG) && !prog_active;
    wire next_irq_mask = exec_boot ? (!vectors_in_boot && boot_read_lock)
                                   : (vectors_in_boot && app_read_lock);

    assign lock_busy = prog_active;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            boot_size   <= bfg_pkg::BOOT_SIZE_RESET;
            size_caught <= 1'b0;
        end else if (ce && !size_caught) begin
            boot_size   <= boot_size_fuses;
            size_caught <= 1'b1;
        end
    end

    // Lock bits: only programmed (to 0) by writes, restored only by chip erase or reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            locks <= bfg_pkg::bfg_locks_t'(4'hf);
        end else if (ce) begin
            if (chip_erase) begin
                locks <= bfg_pkg::bfg_locks_t'(4'hf);
            end else if (lock_write_en) begin
                locks <= locks & lock_write;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prog_active <= 1'b0;
            prog_stalls <= 1'b0;
            cpu_stall   <= 1'b0;
        end else if (ce) begin
            if (next_prog_start) begin
                prog_active <= 1'b1;
                prog_stalls <= target_stall;
                cpu_stall   <= target_stall;
            end else if (prog_done) begin
                prog_active <= 1'b0;
                cpu_stall   <= 1'b0;
            end
        end
    end

    // Busy set on concurrent-region programming; set wins over re-enable clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            region_busy_flag <= 1'b0;
        end else if (ce) begin
            if (next_prog_start && !target_stall) begin
                region_busy_flag <= 1'b1;
            end else if (region_read_reenable && !prog_active) begin
                region_busy_flag <= 1'b0;
            end
        end
    end

    // Rejected accesses never produce grant or programming start
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            store_grant   <= 1'b0;
            load_grant    <= 1'b0;
            access_reject <= 1'b0;
            prog_start    <= 1'b0;
            irq_mask      <= 1'b0;
        end else if (ce) begin
            store_grant   <= next_store_grant;
            load_grant    <= next_load_grant;
            access_reject <= next_reject;
            prog_start    <= next_prog_start;
            irq_mask      <= next_irq_mask;
        end
    end

    // Assertions
    a_app_store_blocked: assert property (@(posedge clk) disable iff (!resetn)
        ce && is_store && !exec_boot |=> !store_grant && !prog_start)
        else $error("store from application region granted");
    a_boot_store_lock: assert property (@(posedge clk) disable iff (!resetn)
        ce && is_store && target_boot && boot_store_lock |=> !store_grant)
        else $error("store to locked boot region granted");
    a_app_store_lock: assert property (@(posedge clk) disable iff (!resetn)
        ce && is_store && !target_boot && app_store_lock |=> access_reject)
        else $error("store to locked application region not rejected");
    a_app_cross_load: assert property (@(posedge clk) disable iff (!resetn)
        ce && is_load && exec_boot && !target_boot && app_read_lock |=> !load_grant)
        else $error("locked application read granted");
    a_boot_cross_load: assert property (@(posedge clk) disable iff (!resetn)
        ce && is_load && !exec_boot && target_boot && boot_read_lock |=> access_reject)
        else $error("locked boot read not rejected");
    a_open_load: assert property (@(posedge clk) disable iff (!resetn)
        ce && is_load && locks == bfg_pkg::bfg_locks_t'(4'hf) && !busy_block |=> load_grant)
        else $error("unlocked load refused");
    a_stall_hold: assert property (@(posedge clk) disable iff (!resetn)
        ce && next_prog_start && target_stall |=> cpu_stall until_with (prog_done && ce))
        else $error("stall dropped before programming done");
    a_busy_set: assert property (@(posedge clk) disable iff (!resetn)
        ce && next_prog_start && !target_stall |=> region_busy_flag && !cpu_stall)
        else $error("busy flag not set for concurrent programming");
    a_lock_sticky: assert property (@(posedge clk) disable iff (!resetn)
        ce && !chip_erase |=> (locks & ~$past(locks)) == 4'h0)
        else $error("lock bit returned unprogrammed without chip erase");
    a_boot_in_stall: assert property (@(posedge clk) disable iff (!resetn)
        exec_boot |-> exec_stall)
        else $error("boot region outside stalling region");

    // Store decisions
    a_store_ok_grant: assert property (@(posedge clk) disable iff (!resetn)
        ce && is_store && store_ok && !lock_busy |=> store_grant)
        else $error("permitted store not granted");
    a_boot_store_open: assert property (@(posedge clk) disable iff (!resetn)
        ce && is_store && exec_boot && target_boot && locks.boot_lock_low && !lock_busy |=> store_grant)
        else $error("store to open boot region refused");
    a_app_store_open: assert property (@(posedge clk) disable iff (!resetn)
        ce && is_store && exec_boot && !target_boot && locks.app_lock_low && !lock_busy |=> store_grant)
        else $error("store to open application region refused");
    a_app_full_lock: assert property (@(posedge clk) disable iff (!resetn)
        ce && is_store && !target_boot && !locks.app_lock_high && !locks.app_lock_low |=> !store_grant)
        else $error("store to fully locked application region granted");
    a_app_prog_none: assert property (@(posedge clk) disable iff (!resetn)
        ce && req.op == bfg_pkg::OP_PROG && !exec_boot |=> !prog_start && access_reject)
        else $error("programming started from application region");
    a_boot_prog_any: assert property (@(posedge clk) disable iff (!resetn)
        ce && req.op == bfg_pkg::OP_PROG && store_ok && !prog_active |=> prog_start)
        else $error("permitted programming not started");
    a_store_busy: assert property (@(posedge clk) disable iff (!resetn)
        ce && is_store && lock_busy |=> !store_grant)
        else $error("store granted while programming active");
    a_prog_once: assert property (@(posedge clk) disable iff (!resetn)
        ce && prog_active |=> !prog_start)
        else $error("programming restarted while active");

    // Load decisions
    a_boot_full_lock: assert property (@(posedge clk) disable iff (!resetn)
        ce && is_load && !exec_boot && target_boot && !locks.boot_lock_high |=> !load_grant)
        else $error("locked boot read granted");
    a_app_full_read: assert property (@(posedge clk) disable iff (!resetn)
        ce && is_load && exec_boot && !target_boot && app_read_lock |=> access_reject)
        else $error("locked application read not rejected");
    a_load_ok_grant: assert property (@(posedge clk) disable iff (!resetn)
        ce && is_load && exec_boot && !target_boot && !app_read_lock && !busy_block |=> load_grant)
        else $error("open application read refused");
    a_boot_read_open: assert property (@(posedge clk) disable iff (!resetn)
        ce && is_load && !exec_boot && target_boot && !boot_read_lock && !busy_block |=> load_grant)
        else $error("open boot read refused");
    a_general_mode: assert property (@(posedge clk) disable iff (!resetn)
        ce && is_load && load_ok && !busy_block |=> load_grant)
        else $error("permitted load refused");
    a_reject_exclusive: assert property (@(posedge clk) disable iff (!resetn)
        access_reject |-> !store_grant && !load_grant && !prog_start)
        else $error("rejected access also granted");

    // Busy region and stall
    a_busy_load_block: assert property (@(posedge clk) disable iff (!resetn)
        ce && is_load && region_busy_flag && !target_stall |=> !load_grant)
        else $error("busy region read granted");
    a_busy_stall_load: assert property (@(posedge clk) disable iff (!resetn)
        ce && is_load && region_busy_flag && target_stall && load_ok |=> load_grant)
        else $error("stalling region read refused while busy");
    a_no_stall_conc: assert property (@(posedge clk) disable iff (!resetn)
        ce && next_prog_start && !target_stall |=> !cpu_stall)
        else $error("CPU stalled for concurrent region programming");
    a_stall_release: assert property (@(posedge clk) disable iff (!resetn)
        ce && cpu_stall && prog_done && !next_prog_start |=> !cpu_stall)
        else $error("stall held after programming done");
    a_busy_hold: assert property (@(posedge clk) disable iff (!resetn)
        region_busy_flag && (!ce || prog_active || !region_read_reenable) |=> region_busy_flag)
        else $error("busy flag dropped without re-enable");
    a_busy_clear: assert property (@(posedge clk) disable iff (!resetn)
        ce && region_busy_flag && region_read_reenable && !prog_active &&
        !(next_prog_start && !target_stall) |=> !region_busy_flag)
        else $error("busy flag not cleared by re-enable");

    // Lock settings, boot size and interrupt masking
    a_lock_write_and: assert property (@(posedge clk) disable iff (!resetn)
        ce && lock_write_en && !chip_erase |=> locks == ($past(locks) & $past(lock_write)))
        else $error("lock write not applied");
    a_chip_erase: assert property (@(posedge clk) disable iff (!resetn)
        ce && chip_erase |=> locks == bfg_pkg::bfg_locks_t'(4'hf))
        else $error("chip erase did not restore locks");
    a_freeze_state: assert property (@(posedge clk) disable iff (!resetn)
        !ce |=> $stable(locks) && $stable(store_grant) && $stable(prog_start))
        else $error("state changed while clock enable low");
    a_boot_size_fixed: assert property (@(posedge clk) disable iff (!resetn)
        size_caught |=> $stable(boot_size))
        else $error("boot size changed after capture");
    a_irq_boot_mask: assert property (@(posedge clk) disable iff (!resetn)
        ce && exec_boot && !vectors_in_boot && boot_read_lock |=> irq_mask)
        else $error("interrupts not masked in locked boot region");
    a_irq_app_mask: assert property (@(posedge clk) disable iff (!resetn)
        ce && !exec_boot && vectors_in_boot && app_read_lock |=> irq_mask)
        else $error("interrupts not masked in locked application region");
    a_irq_open: assert property (@(posedge clk) disable iff (!resetn)
        ce && locks == bfg_pkg::bfg_locks_t'(4'hf) |=> !irq_mask)
        else $error("interrupts masked with all locks open");

    c_irq_mask: cover property (@(posedge clk) disable iff (!resetn) irq_mask);
    c_busy_clear: cover property (@(posedge clk) disable iff (!resetn)
        region_busy_flag ##1 !region_busy_flag);
    c_concurrent_prog: cover property (@(posedge clk) disable iff (!resetn)
        next_prog_start && !target_stall ##[1:20] region_busy_flag && !prog_active);
    c_stall_prog: cover property (@(posedge clk) disable iff (!resetn) cpu_stall ##1 !cpu_stall);
    c_reject: cover property (@(posedge clk) disable iff (!resetn) access_reject);
endmodule : bfg_guard
